//--- design/trc_pkg.sv
// Purpose: Shared constants for the timer run and external interrupt control block
// Assumes: 8-bit register port, byte-wide registers
// Notes: Register indices are byte addresses on the plain register port
package trc_pkg;
    localparam int unsigned TRC_AW = 8;
    localparam int unsigned TRC_DW = 8;
    // Register offsets
    localparam logic [7:0] TRC_OFF_T01CTRL = 8'h88;
    localparam logic [7:0] TRC_OFF_EXTCFG = 8'hE4;
    localparam logic [7:0] TRC_OFF_T2CTRL = 8'hC8;
    localparam logic [7:0] TRC_OFF_CLKCTRL = 8'h8E;
    localparam logic [7:0] TRC_OFF_T3RLH = 8'h93;
    localparam logic [7:0] TRC_OFF_GATE = 8'h89;
    localparam logic [7:0] TRC_OFF_STATUS = 8'hE5;
    // Timer 0/1 control fields
    localparam int unsigned TRC_B_T1_OVF = 7;
    localparam int unsigned TRC_B_T1_RUN = 6;
    localparam int unsigned TRC_B_T0_OVF = 5;
    localparam int unsigned TRC_B_T0_RUN = 4;
    localparam int unsigned TRC_B_X1_FLAG = 3;
    localparam int unsigned TRC_B_X1_TYPE = 2;
    localparam int unsigned TRC_B_X0_FLAG = 1;
    localparam int unsigned TRC_B_X0_TYPE = 0;
    // Ext config fields: polarity bits
    localparam int unsigned TRC_B_X1_POL = 7;
    localparam int unsigned TRC_B_X0_POL = 3;
    // Timer 2 control and clock control fields
    localparam int unsigned TRC_B_T2_EXTCLK = 0;
    localparam int unsigned TRC_B_T2SPLIT = 3;
    localparam int unsigned TRC_B_T2_HICLK = 5;
    localparam int unsigned TRC_B_T2_LOCLK = 4;
    // Gate register fields
    localparam int unsigned TRC_B_T1_GATE = 7;
    localparam int unsigned TRC_B_T0_GATE = 3;
    // Reset values
    localparam logic [7:0] TRC_RST_BYTE = 8'h00;
    // Divider ratios and divider counter width
    localparam int unsigned TRC_SYS_DIV = 12;
    localparam int unsigned TRC_EXT_DIV = 8;
    localparam int unsigned TRC_DIVW = 4;
endpackage

//--- design/trc_timer_ctrl.sv
// Purpose: Run control, overflow and external interrupt flags, timer 2 clock select, timer 3 reload high
// Assumes: Inputs synchronous to mclk per pin sampling policy; counters live outside
// Notes: Overflow, vector and capture strobes are one-cycle pulses from the counter datapath and CPU
`timescale 1ns/1ps
module trc_timer_ctrl
    import trc_pkg::*;
#(
    parameter int unsigned SYNC_STAGES = 2
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire logic [TRC_AW-1:0] reg_addr,
    input wire logic [TRC_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [TRC_DW-1:0] reg_rdata,
    // External pins
    input wire logic ext_irq0_input,
    input wire logic ext_irq1_input,
    input wire logic timer2_ext_clk,
    // Counter datapath events
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer3_reload,
    input wire logic timer3_capture,
    input wire logic [7:0] timer3_count_high,
    // CPU vectoring acknowledges
    input wire logic vector_timer0,
    input wire logic vector_timer1,
    input wire logic vector_ext_irq0,
    input wire logic vector_ext_irq1,
    // Outputs to counters and interrupt controller
    output logic timer0_count_en,
    output logic timer1_count_en,
    output logic timer2_low_tick,
    output logic timer2_high_tick,
    output logic timer3_high_load,
    output logic [7:0] timer3_high_load_value,
    output logic ext_irq0_req,
    output logic ext_irq1_req,
    output logic timer0_irq_req,
    output logic timer1_irq_req
);

    typedef enum logic [2:0]
    {
        TRC_DIV_IDLE = 3'b001,
        TRC_DIV_RUN = 3'b010,
        TRC_DIV_TICK = 3'b100
    } trc_div_state_t;

    function automatic logic trc_hit(input logic [TRC_AW-1:0] a, input logic [TRC_AW-1:0] off);
        trc_hit = (a == off);
    endfunction

    // Hardware set beats any clear in the same cycle
    function automatic logic trc_flag_next(input logic set, input logic keep, input logic clr);
        trc_flag_next = set | (keep & ~clr);
    endfunction

    logic [7:0] t01_q;
    logic [7:0] extcfg_q;
    logic [7:0] t2ctrl_q;
    logic [7:0] clkctrl_q;
    logic [7:0] gate_q;
    logic [7:0] t3rlh_q;
    logic [7:0] rdata_q;

    // Synchronizers for the three pins
    logic [SYNC_STAGES-1:0] sync_q [3];
    logic [2:0] pin_in;
    logic [2:0] pin_s;
    logic [2:0] pin_prev_q;
    assign pin_in = {timer2_ext_clk, ext_irq1_input, ext_irq0_input};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge mclk or negedge resetn)
            begin
                // Reset to the idle high pin level so no false edge follows reset
                if (!resetn)
                    sync_q[gi] <= '1;
                else
                    sync_q[gi] <= {sync_q[gi][SYNC_STAGES-2:0], pin_in[gi]};
            end
            assign pin_s[gi] = sync_q[gi][SYNC_STAGES-1];
        end
    endgenerate

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            pin_prev_q <= '1;
        else
            pin_prev_q <= pin_s;
    end

    // Falling edge of the synchronized timer 2 clock
    wire ext_clk_fall = pin_prev_q[2] & ~pin_s[2];

    // Register decode
    wire wr_t01 = reg_wr & trc_hit(reg_addr, TRC_OFF_T01CTRL);
    wire wr_ext = reg_wr & trc_hit(reg_addr, TRC_OFF_EXTCFG);
    wire wr_t2 = reg_wr & trc_hit(reg_addr, TRC_OFF_T2CTRL);
    wire wr_clk = reg_wr & trc_hit(reg_addr, TRC_OFF_CLKCTRL);
    wire wr_gate = reg_wr & trc_hit(reg_addr, TRC_OFF_GATE);
    wire wr_t3 = reg_wr & trc_hit(reg_addr, TRC_OFF_T3RLH);

    // Write data replaces the control byte, otherwise it holds
    wire [7:0] wsrc = wr_t01 ? reg_wdata : t01_q;

    // Per-channel views of the timer and interrupt fields
    logic [1:0] irq_pol;
    logic [1:0] irq_type;
    logic [1:0] irq_vec;
    logic [1:0] irq_keep;
    logic [1:0] irq_active;
    logic [1:0] irq_prev_active;
    logic [1:0] irq_edge;
    logic [1:0] irq_set;
    logic [1:0] irq_flag_d;
    logic [1:0] tmr_ovf;
    logic [1:0] tmr_vec;
    logic [1:0] tmr_keep;
    logic [1:0] tmr_run;
    logic [1:0] tmr_gate;
    logic [1:0] tmr_flag_d;
    logic [1:0] tmr_en;

    assign irq_pol = {extcfg_q[TRC_B_X1_POL], extcfg_q[TRC_B_X0_POL]};
    assign irq_type = {t01_q[TRC_B_X1_TYPE], t01_q[TRC_B_X0_TYPE]};
    // Vectoring clears only in edge mode
    assign irq_vec = {vector_ext_irq1, vector_ext_irq0} & irq_type;
    assign irq_keep = {wsrc[TRC_B_X1_FLAG], wsrc[TRC_B_X0_FLAG]};
    assign tmr_ovf = {timer1_overflow, timer0_overflow};
    assign tmr_vec = {vector_timer1, vector_timer0};
    assign tmr_keep = {wsrc[TRC_B_T1_OVF], wsrc[TRC_B_T0_OVF]};
    assign tmr_run = {t01_q[TRC_B_T1_RUN], t01_q[TRC_B_T0_RUN]};
    assign tmr_gate = {gate_q[TRC_B_T1_GATE], gate_q[TRC_B_T0_GATE]};

    // Channel 0 pairs timer 0 with interrupt 0, channel 1 timer 1 with interrupt 1
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_chan
            // Active level comes from the polarity bit, never the type bit
            assign irq_active[gi] = pin_s[gi] ~^ irq_pol[gi];
            assign irq_prev_active[gi] = pin_prev_q[gi] ~^ irq_pol[gi];
            assign irq_edge[gi] = irq_active[gi] & ~irq_prev_active[gi];
            assign irq_set[gi] = irq_type[gi] ? irq_edge[gi] : irq_active[gi];
            // Level mode keeps the flag up while the input stays active
            assign irq_flag_d[gi] = trc_flag_next(irq_set[gi], irq_keep[gi], irq_vec[gi]);
            assign tmr_flag_d[gi] = trc_flag_next(tmr_ovf[gi], tmr_keep[gi], tmr_vec[gi]);
            // Enables only gate the counters; the count itself is never touched here
            assign tmr_en[gi] = tmr_run[gi] & (~tmr_gate[gi] | irq_active[gi]);
        end
    endgenerate

    wire [7:0] t01_d = {tmr_flag_d[1], wsrc[TRC_B_T1_RUN], tmr_flag_d[0], wsrc[TRC_B_T0_RUN],
                        irq_flag_d[1], wsrc[TRC_B_X1_TYPE], irq_flag_d[0], wsrc[TRC_B_X0_TYPE]};

    // One short process per register byte
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            t01_q <= TRC_RST_BYTE;
        else
            t01_q <= t01_d;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            extcfg_q <= TRC_RST_BYTE;
        else if (wr_ext)
            extcfg_q <= reg_wdata;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            t2ctrl_q <= TRC_RST_BYTE;
        else if (wr_t2)
            t2ctrl_q <= reg_wdata;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            clkctrl_q <= TRC_RST_BYTE;
        else if (wr_clk)
            clkctrl_q <= reg_wdata;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            gate_q <= TRC_RST_BYTE;
        else if (wr_gate)
            gate_q <= reg_wdata;
    end

    // Capture wins over a same-cycle software write
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            t3rlh_q <= TRC_RST_BYTE;
        else if (timer3_capture)
            t3rlh_q <= timer3_count_high;
        else if (wr_t3)
            t3rlh_q <= reg_wdata;
    end

    // Count enables per timer
    assign timer0_count_en = tmr_en[0];
    assign timer1_count_en = tmr_en[1];

    assign timer3_high_load = timer3_reload;
    assign timer3_high_load_value = t3rlh_q;

    // System clock divide by 12
    logic [TRC_DIVW-1:0] sys_cnt_q;
    wire sys_tick = (sys_cnt_q == TRC_DIVW'(TRC_SYS_DIV - 1));
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            sys_cnt_q <= '0;
        else
            sys_cnt_q <= sys_tick ? '0 : sys_cnt_q + 1'b1;
    end

    // External clock divide by 8, counted on synchronized falling edges
    trc_div_state_t ext_state_q;
    trc_div_state_t ext_state_d;
    logic [TRC_DIVW-1:0] ext_cnt_q;
    wire ext_last = (ext_cnt_q == TRC_DIVW'(TRC_EXT_DIV - 1));
    always_comb
    begin
        ext_state_d = ext_state_q;
        case (ext_state_q)
            TRC_DIV_IDLE:
                if (ext_clk_fall)
                    ext_state_d = TRC_DIV_RUN;
            TRC_DIV_RUN:
                if (ext_clk_fall && ext_last)
                    ext_state_d = TRC_DIV_TICK;
            TRC_DIV_TICK:
                ext_state_d = TRC_DIV_RUN;
            default:
                ext_state_d = TRC_DIV_IDLE;
        endcase
    end
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ext_state_q <= TRC_DIV_IDLE;
            ext_cnt_q <= '0;
        end
        else
        begin
            ext_state_q <= ext_state_d;
            if (ext_clk_fall)
                ext_cnt_q <= ext_last ? '0 : ext_cnt_q + 1'b1;
        end
    end
    wire ext_tick = (ext_state_q == TRC_DIV_TICK);

    // Timer 2 clock selection
    wire t2_base = t2ctrl_q[TRC_B_T2_EXTCLK] ? ext_tick : sys_tick;
    wire t2_split = t2ctrl_q[TRC_B_T2SPLIT];
    logic [1:0] t2_core_sel;
    logic [1:0] t2_src;
    assign t2_core_sel = {clkctrl_q[TRC_B_T2_HICLK], clkctrl_q[TRC_B_T2_LOCLK]};
    // Per-byte selects: 1 picks the core clock, 0 the base source
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_t2_byte
            assign t2_src[gi] = t2_core_sel[gi] ? 1'b1 : t2_base;
        end
    endgenerate
    assign timer2_low_tick = t2_src[0];
    assign timer2_high_tick = t2_split ? t2_src[1] : t2_src[0];

    // Interrupt requests follow the flags
    assign timer0_irq_req = t01_q[TRC_B_T0_OVF];
    assign timer1_irq_req = t01_q[TRC_B_T1_OVF];
    assign ext_irq0_req = t01_q[TRC_B_X0_FLAG];
    assign ext_irq1_req = t01_q[TRC_B_X1_FLAG];

    // Read mux; status register exposes synchronized pins and divider state
    wire [7:0] status_w = {4'h0, ext_tick, pin_s};
    wire [7:0] rd_mux =
        trc_hit(reg_addr, TRC_OFF_T01CTRL) ? t01_q :
        trc_hit(reg_addr, TRC_OFF_EXTCFG) ? extcfg_q :
        trc_hit(reg_addr, TRC_OFF_T2CTRL) ? t2ctrl_q :
        trc_hit(reg_addr, TRC_OFF_CLKCTRL) ? clkctrl_q :
        trc_hit(reg_addr, TRC_OFF_GATE) ? gate_q :
        trc_hit(reg_addr, TRC_OFF_T3RLH) ? t3rlh_q :
        trc_hit(reg_addr, TRC_OFF_STATUS) ? status_w : TRC_RST_BYTE;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            rdata_q <= TRC_RST_BYTE;
        else if (reg_rd)
            rdata_q <= rd_mux;
        else
            rdata_q <= TRC_RST_BYTE;
    end
    assign reg_rdata = rdata_q;

endmodule

//--- tb/trc_timer_ctrl_chk.sv
// Purpose: Temporal checks on timer 0/1 overflow flags, timer 3 reload/capture and read data
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to the design top; samples design inputs as triggers and checks design-driven outputs
`timescale 1ns/1ps
module trc_timer_ctrl_chk
    import trc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [TRC_DW-1:0] reg_rdata,
    // Events
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic vector_timer0,
    input wire logic vector_timer1,
    input wire logic timer3_reload,
    input wire logic timer3_capture,
    input wire logic [7:0] timer3_count_high,
    // Outputs watched
    input wire logic timer0_irq_req,
    input wire logic timer1_irq_req,
    input wire logic timer3_high_load,
    input wire logic [7:0] timer3_high_load_value
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    sequence s_cap_lands;
        ##1 (timer3_high_load_value == $past(timer3_count_high));
    endsequence
    sequence s_vec1_only;
        vector_timer1 && !timer1_overflow && !reg_wr;
    endsequence
    a_t1_flag_sets: assert property (timer1_overflow |=> timer1_irq_req)
        else $error("timer 1 flag not set by overflow");
    a_t0_flag_sets: assert property (timer0_overflow |=> timer0_irq_req)
        else $error("timer 0 flag not set by overflow");
    a_t1_vec_clear: assert property (s_vec1_only |=> !timer1_irq_req)
        else $error("timer 1 flag survived vectoring");
    a_t0_vec_clear: assert property (vector_timer0 && !timer0_overflow && !reg_wr |=> !timer0_irq_req)
        else $error("timer 0 flag survived vectoring");
    a_t1_flag_holds: assert property (timer1_irq_req && !vector_timer1 && !reg_wr |=> $stable(timer1_irq_req))
        else $error("timer 1 flag dropped on its own");
    a_reload_strobe: assert property (timer3_reload |-> timer3_high_load)
        else $error("reload strobe not passed to high byte");
    a_capture_loads: assert property (timer3_capture |-> s_cap_lands)
        else $error("capture did not take the high count");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the read slot");
endmodule
bind trc_timer_ctrl trc_timer_ctrl_chk i_trc_timer_ctrl_chk (.mclk(mclk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
    .vector_timer0(vector_timer0), .vector_timer1(vector_timer1), .timer3_reload(timer3_reload),
    .timer3_capture(timer3_capture), .timer3_count_high(timer3_count_high), .timer0_irq_req(timer0_irq_req),
    .timer1_irq_req(timer1_irq_req), .timer3_high_load(timer3_high_load),
    .timer3_high_load_value(timer3_high_load_value));

//--- tb/trc_pin_model.sv
// Purpose: External pins: interrupt levels and a bursty timer 2 clock
// Assumes: Clock period 14 ns, unrelated to mclk
// Notes: Clock stands high between bursts so edge counts stay exact
`timescale 1ns/1ps
module trc_pin_model (
    // Commanded levels
    input wire logic [1:0] irq_lvl,
    // Pins
    output logic ext_irq0_input,
    output logic ext_irq1_input,
    output logic timer2_ext_clk
);
    assign ext_irq0_input = irq_lvl[0];
    assign ext_irq1_input = irq_lvl[1];
    initial timer2_ext_clk = 1'b1;
    task automatic burst(input int n);
        repeat (n)
        begin
            #7 timer2_ext_clk = 1'b0;
            #7 timer2_ext_clk = 1'b1;
        end
    endtask
endmodule

//--- tb/trc_timer_ctrl_bench.sv
// Purpose: Directed bench for run control, flags, timer 2 ticks and timer 3
// Assumes: Pins idle inactive for active-low polarity after reset
// Notes: Events driven from one vector so a pulse task serves all
`timescale 1ns/1ps
module trc_timer_ctrl_bench;
    import trc_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] t3_cnt = 8'h00;
    logic [7:0] ev = 8'h00;
    logic [1:0] irq_lvl = 2'b11;
    logic [7:0] rdata, t3_val;
    logic en0, en1, lo_tick, hi_tick, t3_ld, irq0, irq1, tq0, tq1, p0, p1, xclk;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    int lo_n = 0;
    always #2.5 mclk = ~mclk;
    trc_timer_ctrl i_trc_timer_ctrl (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .ext_irq0_input(p0), .ext_irq1_input(p1),
        .timer2_ext_clk(xclk), .timer0_overflow(ev[0]), .timer1_overflow(ev[1]), .timer3_reload(ev[6]),
        .timer3_capture(ev[7]), .timer3_count_high(t3_cnt), .vector_timer0(ev[2]), .vector_timer1(ev[3]),
        .vector_ext_irq0(ev[4]), .vector_ext_irq1(ev[5]), .timer0_count_en(en0), .timer1_count_en(en1),
        .timer2_low_tick(lo_tick), .timer2_high_tick(hi_tick), .timer3_high_load(t3_ld),
        .timer3_high_load_value(t3_val), .ext_irq0_req(irq0), .ext_irq1_req(irq1), .timer0_irq_req(tq0),
        .timer1_irq_req(tq1));
    trc_pin_model i_trc_pin_model (.irq_lvl(irq_lvl), .ext_irq0_input(p0), .ext_irq1_input(p1),
        .timer2_ext_clk(xclk));
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (lo_tick === 1'b1)
            lo_n <= lo_n + 1;
        if (cyc == 5000)
        begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge mclk);
        ev <= m;
        @(posedge mclk);
        ev <= 8'h00;
        #1;
    endtask
    task automatic t_regs;
        logic [7:0] offs [6] = '{TRC_OFF_T01CTRL, TRC_OFF_EXTCFG, TRC_OFF_T2CTRL, TRC_OFF_CLKCTRL,
            TRC_OFF_T3RLH, TRC_OFF_GATE};
        foreach (offs[i]) rd(offs[i], TRC_RST_BYTE, "reset value");
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h00, "unmapped read");
        $display("test regs done");
    endtask
    task automatic t_run;
        wr(TRC_OFF_EXTCFG, 8'h88);
        irq_lvl <= 2'b00;
        w(4);
        wr(TRC_OFF_T01CTRL, 8'h50);
        chk("run enables", 8'h03, {6'h00, en1, en0});
        rd(TRC_OFF_T01CTRL, 8'h50, "run readback");
        wr(TRC_OFF_T01CTRL, 8'h10);
        wr(TRC_OFF_GATE, 8'h08);
        chk("gated off", 8'h00, {6'h00, en1, en0});
        irq_lvl <= 2'b01;
        w(4);
        chk("gated on", 8'h01, {7'h00, en0});
        wr(TRC_OFF_EXTCFG, 8'h80);
        w(1);
        chk("low polarity", 8'h00, {7'h00, en0});
        wr(TRC_OFF_EXTCFG, 8'h88);
        irq_lvl <= 2'b00;
        wr(TRC_OFF_GATE, 8'h00);
        w(3);
        wr(TRC_OFF_T01CTRL, 8'h00);
        $display("test run done");
    endtask
    task automatic t_ovf;
        pulse(8'h0A);
        chk("set beats vector", 8'h02, {6'h00, tq1, tq0});
        rd(TRC_OFF_T01CTRL, 8'h80, "timer 1 flag");
        pulse(8'h08);
        chk("vector clears", 8'h00, {6'h00, tq1, tq0});
        pulse(8'h01);
        rd(TRC_OFF_T01CTRL, 8'h20, "timer 0 flag");
        wr(TRC_OFF_T01CTRL, 8'h00);
        chk("software clear", 8'h00, {6'h00, tq1, tq0});
        $display("test overflow done");
    endtask
    task automatic t_ext(input int i);
        logic [7:0] ty;
        ty = 8'(8'h01 << (2 * i));
        wr(TRC_OFF_T01CTRL, ty);
        irq_lvl[i] <= 1'b1;
        w(4);
        chk("edge flag", 8'h01, {6'h00, irq1, irq0} >> i);
        pulse(8'(8'h10 << i));
        w(4);
        chk("edge once", 8'h00, {6'h00, irq1, irq0} >> i);
        wr(TRC_OFF_T01CTRL, 8'h00);
        w(4);
        chk("level flag", 8'h01, {6'h00, irq1, irq0} >> i);
        pulse(8'(8'h10 << i));
        chk("level kept", 8'h01, {6'h00, irq1, irq0} >> i);
        irq_lvl[i] <= 1'b0;
        w(3);
        wr(TRC_OFF_T01CTRL, 8'h00);
        w(2);
        chk("level released", 8'h00, {6'h00, irq1, irq0} >> i);
        $display("test ext irq done");
    endtask
    task automatic t_t3;
        wr(TRC_OFF_T3RLH, 8'hA5);
        @(posedge mclk);
        ev <= 8'h40;
        #1 chk("reload value", 8'hA5, t3_val & {8{t3_ld}});
        @(posedge mclk);
        ev <= 8'h80;
        t3_cnt <= 8'h3C;
        pulse(8'h00);
        rd(TRC_OFF_T3RLH, 8'h3C, "captured high");
        $display("test timer3 done");
    endtask
    task automatic t_t2;
        int a;
        a = lo_n;
        w(120);
        chk("core ticks", 8'd10, 8'(lo_n - a));
        wr(TRC_OFF_T2CTRL, 8'h01);
        a = lo_n;
        i_trc_pin_model.burst(16);
        w(6);
        chk("ext ticks", 8'd2, 8'(lo_n - a));
        wr(TRC_OFF_T2CTRL, 8'h09);
        wr(TRC_OFF_CLKCTRL, 8'h20);
        a = lo_n;
        i_trc_pin_model.burst(8);
        w(6);
        chk("split low ticks", 8'd1, 8'(lo_n - a));
        chk("split high core", 8'h01, {7'h00, hi_tick});
        $display("test timer2 done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        t_run();
        t_ovf();
        t_ext(0);
        t_ext(1);
        t_t3();
        t_t2();
        end_of_test();
    end
endmodule
